//--- core/sbst_pkg.sv
// package for the sram boundary-scan test access port
package sbst_pkg;

  // ----------------------------------------------------------------
  // controller states, gray codes along the common path
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SEL_DR  = 4'h3,
    ST_CAP_DR  = 4'h2,
    ST_SH_DR   = 4'h6,
    ST_EX1_DR  = 4'h7,
    ST_PAU_DR  = 4'h5,
    ST_EX2_DR  = 4'h4,
    ST_UPD_DR  = 4'hC,
    ST_SEL_IR  = 4'hD,
    ST_CAP_IR  = 4'hF,
    ST_SH_IR   = 4'hE,
    ST_EX1_IR  = 4'hA,
    ST_PAU_IR  = 4'hB,
    ST_EX2_IR  = 4'h9,
    ST_UPD_IR  = 4'h8
  } sbst_state_e;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam int IR_W = 3;
  typedef enum logic [IR_W-1:0] {
    OP_EXT_TEST   = 3'h0,
    OP_ID_READ    = 3'h1,
    OP_HIZ_SAMPLE = 3'h2,
    OP_RSVD_ENG3  = 3'h3,
    OP_SAMPLE_PRE = 3'h4,
    OP_RSVD_ENG5  = 3'h5,
    OP_RSVD_ENG6  = 3'h6,
    OP_BYPASS     = 3'h7
  } sbst_op_e;

  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  localparam int         ID_W           = 32;
  localparam int         BSR_LEN        = 109;
  localparam int         RESET_TMS_HIGH = 5;
  localparam int         SYNC_STAGES    = 2;

  // two-signal view of the serial output pin
  typedef struct packed {
    logic data;
    logic oe;
  } sbst_tdo_s;

endpackage : sbst_pkg

//--- core/sbst_tap.sv
// boundary-scan test access port of the sram, sampled on the system clock
`timescale 1ns/10ps
`default_nettype none

module sbst_tap
  import sbst_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_CODE = 32'h0000_0001  // arbitrary value, bit 0 start bit
) (
  input  wire  logic               i_clk_sys,
  input  wire  logic               i_rst_n,
  input  wire  logic               i_tck,
  input  wire  logic               i_tms,
  input  wire  logic               i_tdi,
  input  wire  logic [BSR_LEN-1:0] i_ring_sample,
  output logic                     o_tdo,
  output logic                     o_tdo_oe,
  output logic [BSR_LEN-1:0]       o_ring_drive,
  output logic                     o_ring_drive_en,
  output logic                     o_mem_out_hiz
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] tck_sync;
  logic [SYNC_STAGES-1:0] tms_sync;
  logic [SYNC_STAGES-1:0] tdi_sync;
  logic                   tck_last;

  always_ff @(posedge i_clk_sys) begin
    tck_sync <= {tck_sync[0], i_tck};
    tms_sync <= {tms_sync[0], i_tms};
    tdi_sync <= {tdi_sync[0], i_tdi};
    if (!i_rst_n) begin
      tck_last <= 1'b0;
    end else begin
      tck_last <= tck_sync[1];
    end
  end

  wire tck_s   = tck_sync[1];
  wire tms_s   = tms_sync[1];
  wire tdi_s   = tdi_sync[1];
  wire tck_ris = tck_s & ~tck_last;
  wire tck_fal = ~tck_s & tck_last;

  // ----------------------------------------------------------------
  // controller
  // ----------------------------------------------------------------
  sbst_state_e state;
  sbst_state_e next_state;

  function automatic sbst_state_e tap_next(input sbst_state_e s, input logic m);
    case (s)
      ST_RESET:  tap_next = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      default:   tap_next = ST_RESET;
    endcase
  endfunction : tap_next

  // the graph alone guarantees reset after five high samples from any state
  assign next_state = tap_next(state, tms_s);

  // system reset stands in for power-up; no test reset pin exists
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state <= ST_RESET;
    end else if (tck_ris) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // instruction and data registers
  // ----------------------------------------------------------------
  logic [IR_W-1:0]    ir_shift;
  sbst_op_e           ir_op;
  logic               bypass_bit;
  logic [ID_W-1:0]    id_shift;
  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] bsr_update;

  wire sel_bsr = (ir_op == OP_EXT_TEST) | (ir_op == OP_HIZ_SAMPLE)
               | (ir_op == OP_SAMPLE_PRE);
  wire sel_id  = (ir_op == OP_ID_READ);
  // reserved codes fall back to bypass so the path is never open
  wire sel_byp = ~sel_bsr & ~sel_id;

  wire in_cap_dr = (state == ST_CAP_DR);
  wire in_sh_dr  = (state == ST_SH_DR);
  wire in_cap_ir = (state == ST_CAP_IR);
  wire in_sh_ir  = (state == ST_SH_IR);
  wire dr_cap    = tck_ris & in_cap_dr;
  wire dr_shift  = tck_ris & in_sh_dr;

  // capture-IR: high bit stays unknown-free zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ir_shift <= '0;
    end else if (tck_ris && in_cap_ir) begin
      ir_shift <= {1'b0, IR_CAPTURE_PAT};
    end else if (tck_ris && in_sh_ir) begin
      ir_shift <= {tdi_s, ir_shift[IR_W-1:1]};
    end
  end

  // update at the falling edge inside update-IR keeps it off the shift edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ir_op <= OP_ID_READ;
    end else if (tck_fal && state == ST_RESET) begin
      ir_op <= OP_ID_READ;
    end else if (tck_fal && state == ST_UPD_IR) begin
      ir_op <= sbst_op_e'(ir_shift);
    end
  end

  // captures zero when bypass is selected; otherwise holds last shifted bit
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      bypass_bit <= 1'b0;
    end else if (dr_cap && sel_byp) begin
      bypass_bit <= 1'b0;
    end else if (dr_shift && sel_byp) begin
      bypass_bit <= tdi_s;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      id_shift <= '0;
    end else if (dr_cap && sel_id) begin
      id_shift <= ID_CODE;
    end else if (dr_shift && sel_id) begin
      id_shift <= {tdi_s, id_shift[ID_W-1:1]};
    end
  end

  // ring bits come from the memory's own clock domain; the tester keeps
  // them steady across capture, so no synchroniser is placed on them
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      bsr_shift <= '0;
    end else if (dr_cap && sel_bsr) begin
      bsr_shift <= i_ring_sample;
    end else if (dr_shift && sel_bsr) begin
      bsr_shift <= {tdi_s, bsr_shift[BSR_LEN-1:1]};
    end
  end

  // update stage changes only under sample/preload or external test
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      bsr_update <= '0;
    end else if (tck_fal && state == ST_UPD_DR
                 && (ir_op == OP_SAMPLE_PRE || ir_op == OP_EXT_TEST)) begin
      bsr_update <= bsr_shift;
    end
  end

  // ----------------------------------------------------------------
  // serial output and memory-side controls
  // ----------------------------------------------------------------
  wire dr_lsb = sel_bsr ? bsr_shift[0] : (sel_id ? id_shift[0] : bypass_bit);
  wire next_tdo = in_sh_ir ? ir_shift[0] : dr_lsb;
  wire ext_on   = (ir_op == OP_EXT_TEST);
  // top bit is the internal cell that lets external test drive outputs
  wire ext_drive = ext_on & bsr_update[BSR_LEN-1];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fal) begin
      o_tdo    <= next_tdo;
      o_tdo_oe <= in_sh_ir | in_sh_dr;
    end
  end

  // memory core path is untouched; only these test-mode controls leave
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_ring_drive    <= '0;
      o_ring_drive_en <= 1'b0;
      o_mem_out_hiz   <= 1'b0;
    end else begin
      o_ring_drive    <= bsr_update;
      o_ring_drive_en <= ext_drive;
      o_mem_out_hiz   <= (ext_on & ~ext_drive) | (ir_op == OP_HIZ_SAMPLE);
    end
  end

endmodule : sbst_tap

`default_nettype wire

//--- testbench/sbst_tap_assertions.sv
// concurrent checks on the pins of the boundary-scan port
`timescale 1ns/10ps
`default_nettype none
module sbst_tap_assertions
  import sbst_pkg::*;
(
  input wire logic               i_clk_sys,
  input wire logic               i_rst_n,
  input wire logic               i_tck,
  input wire logic               i_tms,
  input wire logic               i_tdi,
  input wire logic [BSR_LEN-1:0] i_ring_sample,
  input wire logic               o_tdo,
  input wire logic               o_tdo_oe,
  input wire logic [BSR_LEN-1:0] o_ring_drive,
  input wire logic               o_ring_drive_en,
  input wire logic               o_mem_out_hiz
);
  // ----------------------------------------------------------------
  // mode select seen at each test clock rise
  // ----------------------------------------------------------------
  logic       last_tms;
  logic [2:0] high_cnt;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      last_tms <= 1'b0;
      high_cnt <= 3'h0;
    end else if ($rose(i_tck)) begin
      last_tms <= i_tms;
      high_cnt <= i_tms ? high_cnt + {2'h0, high_cnt != 3'h7} : 3'h0;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_tdo_on_fall: assert property (
    $changed({o_tdo, o_tdo_oe}) |-> !$past(i_tck, 2) && !$past(i_tck, 3))
    else $error("serial output moved while test clock high");
  chk_oe_start: assert property ($rose(o_tdo_oe) |-> !last_tms)
    else $error("serial output enabled outside a shift state");
  chk_oe_stop: assert property ($fell(o_tdo_oe) |-> last_tms)
    else $error("serial output released while still shifting");
  chk_mode_on_fall: assert property (
    $changed({o_ring_drive_en, o_mem_out_hiz}) |-> !$past(i_tck, 2))
    else $error("instruction effect outside test clock fall");
  chk_ring_update: assert property (
    $changed(o_ring_drive) |-> last_tms && !$past(i_tck, 2))
    else $error("ring drive changed outside update");
  chk_drive_excl: assert property (!(o_ring_drive_en && o_mem_out_hiz))
    else $error("outputs driven and forced off together");
  chk_drive_cell: assert property (
    o_ring_drive_en && $stable(o_ring_drive) |-> o_ring_drive[BSR_LEN-1])
    else $error("drive enabled with internal cell low");
  chk_tms_reset: assert property (
    $rose(i_tck) && i_tms && high_cnt >= 3'h4
      |-> ##[1:40] !(o_tdo_oe || o_ring_drive_en || o_mem_out_hiz))
    else $error("five high mode selects did not reset");
  cover property ($rose(o_tdo_oe));
  cover property ($rose(o_ring_drive_en));
  cover property ($rose(o_mem_out_hiz));
endmodule : sbst_tap_assertions
`default_nettype wire

//--- testbench/sbst_tester.sv
// board scan controller model driving the test pins
`timescale 1ns/10ps
`default_nettype none
module sbst_tester (
  input  wire logic i_clk_sys,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe,
  output var  logic o_tck,
  output var  logic o_tms,
  output var  logic o_tdi
);
  logic last_tdo;
  // released pin must not look like a valid bit
  wire  tdo_pin = i_tdo_oe ? i_tdo : ~last_tdo;
  initial begin
    o_tck    = 1'b0;
    o_tms    = 1'b1;
    o_tdi    = 1'b1;
    last_tdo = 1'b0;
  end
  always @(posedge i_clk_sys) if (i_tdo_oe) last_tdo <= i_tdo;
  // one test clock period of 24 system clocks; clock stands low between steps
  task automatic step(input logic tms_v, input logic tdi_v, output logic pin);
    @(posedge i_clk_sys);
    o_tms <= tms_v;
    o_tdi <= tdi_v;
    repeat (2) @(posedge i_clk_sys);
    o_tck <= 1'b1;
    repeat (12) @(posedge i_clk_sys);
    o_tck <= 1'b0;
    repeat (9) @(posedge i_clk_sys);
    @(negedge i_clk_sys) pin = tdo_pin;
  endtask : step
endmodule : sbst_tester
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the boundary-scan port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sbst_pkg::*;
  localparam logic [ID_W-1:0]    ID_VAL  = 32'h0000_ACE1; // arbitrary value, start bit set
  localparam logic [BSR_LEN-1:0] PAT_IN  = 109'h1_234_5678_9ABC_DEF0_1357_9BDF_2468;
  // top digit lands on bit 108, the internal drive cell
  localparam logic [BSR_LEN-1:0] PAT_OUT = 109'h1_ACE_0F0F_5A5A_C3C3_9669_0FF0_1234;
  localparam logic [BSR_LEN-1:0] PAT_OFF = 109'h0_ACE_0F0F_5A5A_C3C3_9669_0FF0_1234;
  logic               clk, rst_n, tck, tms, tdi, tdo, tdo_oe, drive_en, hiz;
  logic [BSR_LEN-1:0] ring_in, drive, got;
  int                 fails = 0, n_tests = 0, cycles = 0;
  sbst_tap #(.ID_CODE(ID_VAL)) DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .i_ring_sample(ring_in), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .o_ring_drive(drive), .o_ring_drive_en(drive_en), .o_mem_out_hiz(hiz));
  sbst_tester tester (.i_clk_sys(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck),
    .o_tms(tms), .o_tdi(tdi));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (++cycles == 30000) begin
    fails++;
    summarize();
  end
  task automatic summarize();
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [BSR_LEN-1:0] exp,
                       input logic [BSR_LEN-1:0] seen);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // from idle: shift n bits lsb first, collect tdo, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [BSR_LEN-1:0] din,
                      output logic [BSR_LEN-1:0] dout);
    logic p;
    dout = '0;
    tester.step(1'b1, 1'b0, p);
    if (ir) tester.step(1'b1, 1'b0, p);
    tester.step(1'b0, 1'b0, p);
    tester.step(1'b0, 1'b0, dout[0]);
    for (int i = 0; i < n; i++) begin
      tester.step(i == n - 1, din[i], p);
      if (i < n - 1) dout[i + 1] = p;
    end
    tester.step(1'b1, 1'b0, p);
    tester.step(1'b0, 1'b0, p);
  endtask : scan
  task automatic load_ir(input sbst_op_e op);
    scan(1'b1, IR_W, {106'h0, op}, got);
    check("ir capture", IR_CAPTURE_PAT, got);
  endtask : load_ir
  task automatic t_identity(input string what);
    logic p;
    tester.step(1'b0, 1'b0, p);
    scan(1'b0, ID_W, '0, got);
    check(what, ID_VAL, got);
  endtask : t_identity
  task automatic t_bypass();
    load_ir(OP_BYPASS);
    scan(1'b0, 8, 109'hB5, got);
    check("bypass path", 109'h6A, got);
  endtask : t_bypass
  task automatic t_preload_extest();
    load_ir(OP_SAMPLE_PRE);
    scan(1'b0, BSR_LEN, PAT_OUT, got);
    check("sample snapshot", PAT_IN, got);
    check("sample modes", '0, {drive_en, hiz});
    check("preload vector", PAT_OUT, drive);
    load_ir(OP_EXT_TEST);
    check("extest on", 2'h2, {drive_en, hiz});
    scan(1'b0, BSR_LEN, PAT_OFF, got);
    check("extest capture", PAT_IN, got);
    check("extest off", 2'h1, {drive_en, hiz});
  endtask : t_preload_extest
  task automatic t_hiz();
    load_ir(OP_HIZ_SAMPLE);
    check("hiz mode", 2'h1, {drive_en, hiz});
    scan(1'b0, BSR_LEN, PAT_OUT, got);
    check("hiz capture", PAT_IN, got);
  endtask : t_hiz
  task automatic t_tms_reset();
    logic p;
    repeat (5) tester.step(1'b1, 1'b0, p);
    check("after tms reset", '0, {tdo_oe, drive_en, hiz});
    t_identity("identity again");
  endtask : t_tms_reset
  initial begin
    rst_n   = 1'b0;
    ring_in <= PAT_IN;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("power-up pins", '0, {tdo_oe, drive_en, hiz});
    t_identity("identity");
    t_bypass();
    t_preload_extest();
    t_hiz();
    t_tms_reset();
    summarize();
  end
endmodule : testbench
bind sbst_tap sbst_tap_assertions chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi), .i_ring_sample(i_ring_sample),
  .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_ring_drive(o_ring_drive),
  .o_ring_drive_en(o_ring_drive_en), .o_mem_out_hiz(o_mem_out_hiz));
`default_nettype wire
